// ---- hdl/pie_ctrl.sv ----
// Purpose: peripheral interrupt enables (groups 2, 3) and priorities (1..3)
// Assumes: synchronous active-low reset, request flags from same clock
// Notes: registers on Avalon-MM, one wait cycle per access
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`include "pie_params.svh"
module pie_ctrl (
	input  wire logic              clock,       // 50 MHz clock
	input  wire logic              resetn,      // sync reset, active low
	input  wire pie_pkg::pie_avreq_s avReq,     // avalon request
	output pie_pkg::pie_avrsp_s    avRsp,       // avalon response
	input  wire pie_pkg::pie_srcvec_s srcFlags, // peripheral flags
	output logic                   irqHigh,     // high-priority request
	output logic                   irqLow,      // low-priority request
	output logic                   irqOut       // status interrupt
);
	import pie_pkg::*;

	localparam int NGRP = 3;

	// group 2: 7 osc fail, 6 comparator, 3 bus collision, 2 voltage, 1 timer3, 0 ccp2
	// group 3: 6 display, 5 serial2 rx, 4 serial2 tx
	logic [7:0] en2_r, en2_nxt;
	logic [7:0] en3_r, en3_nxt;
	logic [7:0] pri1_r, pri1_nxt;
	logic [7:0] pri2_r, pri2_nxt;
	logic [7:0] pri3_r, pri3_nxt;
	logic       globalPrio_r, globalPrio_nxt;
	logic [`PIE_STAT_W-1:0] stat_r, stat_nxt;
	logic [`PIE_STAT_W-1:0] statEn_r, statEn_nxt;
	logic       highQ_r, lowQ_r;
	pie_bus_e   bus_r, bus_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	logic [7:0] en1Fixed;
	logic [NGRP*8-1:0] flagsAll, enAll, priAll, hiAll, loAll;
	logic       irqHighNow, irqLowNow;
	logic       accWr, accRd;

	// group 1 enables live outside this block, so pass bits 6..0 of those requests through
	assign en1Fixed = `PIE_PRI1_MASK;
	assign flagsAll = {srcFlags.grp3, srcFlags.grp2, srcFlags.grp1};
	assign enAll    = {en3_r, en2_r, en1Fixed};
	assign priAll   = {pri3_r, pri2_r, pri1_r};

	genvar g;
	generate
		for (g = 0; g < NGRP; g++) begin : gRoute
			pie_route #(.WIDTH(8)) uRoute (
				.flags   (flagsAll[g*8 +: 8]),
				.enables (enAll[g*8 +: 8]),
				.prios   (priAll[g*8 +: 8]),
				.prioOn  (globalPrio_r),
				.reqHigh (hiAll[g*8 +: 8]),
				.reqLow  (loAll[g*8 +: 8])
			);
		end
	endgenerate

	assign irqHighNow = |hiAll;
	assign irqLowNow  = |loAll;

	// one wait state: the access completes in the DONE state
	assign accWr = (bus_r == PIE_DONE) && avReq.write;
	assign accRd = (bus_r == PIE_DONE) && avReq.read;

	always_comb begin
		bus_nxt = bus_r;
		unique case (bus_r)
			PIE_IDLE: begin
				if (avReq.read || avReq.write) bus_nxt = PIE_DONE;
			end
			PIE_DONE: begin
				bus_nxt = PIE_IDLE;
			end
			default: bus_nxt = PIE_IDLE;
		endcase
	end

	always_comb begin
		en2_nxt        = en2_r;
		en3_nxt        = en3_r;
		pri1_nxt       = pri1_r;
		pri2_nxt       = pri2_r;
		pri3_nxt       = pri3_r;
		globalPrio_nxt = globalPrio_r;
		statEn_nxt     = statEn_r;
		stat_nxt       = stat_r;
		if (accWr) begin
			unique case (avReq.address)
				`PIE_OFF_EN2:  en2_nxt = avReq.writedata[7:0] & `PIE_EN2_MASK;
				`PIE_OFF_EN3:  en3_nxt = avReq.writedata[7:0] & `PIE_EN3_MASK;
				`PIE_OFF_PRI1: pri1_nxt = avReq.writedata[7:0] & `PIE_PRI1_MASK;
				`PIE_OFF_PRI2: pri2_nxt = avReq.writedata[7:0] & `PIE_PRI2_MASK;
				`PIE_OFF_PRI3: pri3_nxt = avReq.writedata[7:0] & `PIE_PRI3_MASK;
				`PIE_OFF_CTRL: begin
					globalPrio_nxt = avReq.writedata[0];
					statEn_nxt     = avReq.writedata[`PIE_STAT_W:1];
				end
				`PIE_OFF_STCLR: stat_nxt = stat_r & ~avReq.writedata[`PIE_STAT_W-1:0];
				default: ;
			endcase
		end
		// set after clear: an event in the clearing cycle survives
		stat_nxt = stat_nxt | {globalPrio_r, irqLowNow & ~lowQ_r, irqHighNow & ~highQ_r};
	end

	always_comb begin
		rdata_nxt = '0;
		if (accRd) begin
			unique case (avReq.address)
				`PIE_OFF_EN2:    rdata_nxt[7:0] = en2_r;
				`PIE_OFF_EN3:    rdata_nxt[7:0] = en3_r;
				`PIE_OFF_PRI1:   rdata_nxt[7:0] = pri1_r;
				`PIE_OFF_PRI2:   rdata_nxt[7:0] = pri2_r;
				`PIE_OFF_PRI3:   rdata_nxt[7:0] = pri3_r;
				`PIE_OFF_CTRL:   rdata_nxt[`PIE_STAT_W:0] = {statEn_r, globalPrio_r};
				`PIE_OFF_STATUS: rdata_nxt[`PIE_STAT_W-1:0] = stat_r;
				default:         rdata_nxt = '0;   // write-only clear reads zero
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			bus_r        <= PIE_IDLE;
			en2_r        <= `PIE_EN_RST;
			en3_r        <= `PIE_EN_RST;
			pri1_r       <= `PIE_PRI_RST & `PIE_PRI1_MASK;
			pri2_r       <= `PIE_PRI_RST & `PIE_PRI2_MASK;
			pri3_r       <= `PIE_PRI_RST & `PIE_PRI3_MASK;
			globalPrio_r <= 1'b0;
			stat_r       <= '0;
			statEn_r     <= '0;
			highQ_r      <= 1'b0;
			lowQ_r       <= 1'b0;
			rdata_r      <= '0;
			irqHigh      <= 1'b0;
			irqLow       <= 1'b0;
		end else begin
			bus_r        <= bus_nxt;
			en2_r        <= en2_nxt;
			en3_r        <= en3_nxt;
			pri1_r       <= pri1_nxt;
			pri2_r       <= pri2_nxt;
			pri3_r       <= pri3_nxt;
			globalPrio_r <= globalPrio_nxt;
			stat_r       <= stat_nxt;
			statEn_r     <= statEn_nxt;
			highQ_r      <= irqHighNow;
			lowQ_r       <= irqLowNow;
			rdata_r      <= rdata_nxt;
			irqHigh      <= irqHighNow;
			irqLow       <= irqLowNow;
		end
	end

	assign avRsp.waitrequest = (avReq.read || avReq.write) && (bus_r != PIE_DONE);
	assign avRsp.readdata    = rdata_nxt;
	assign irqOut            = |(stat_r & statEn_r);

	// ---- checks ----
	a_osc_fail_gate: assert property (@(posedge clock) disable iff (!resetn)
		(!en2_r[7] && !globalPrio_r && (srcFlags.grp2 & en2_r) == 8'h00
		 && srcFlags.grp1 == 8'h00 && (srcFlags.grp3 & en3_r) == 8'h00) |=> !irqHigh)
		else $error("masked request reached core");
	a_comp_pass: assert property (@(posedge clock) disable iff (!resetn)
		(srcFlags.grp2[6] && en2_r[6] && !globalPrio_r) |=> irqHigh)
		else $error("comparator request lost");
	a_bcol_pass: assert property (@(posedge clock) disable iff (!resetn)
		(srcFlags.grp2[3] && en2_r[3] && !globalPrio_r) |=> irqHigh)
		else $error("bus collision request lost");
	a_volt_pass: assert property (@(posedge clock) disable iff (!resetn)
		(srcFlags.grp2[2] && en2_r[2] && globalPrio_r && pri2_r[2]) |=> irqHigh)
		else $error("voltage request misrouted");
	a_tmr3_low: assert property (@(posedge clock) disable iff (!resetn)
		(srcFlags.grp2[1] && en2_r[1] && globalPrio_r && !pri2_r[1]) |=> irqLow)
		else $error("timer3 low request lost");
	a_ccp2_pass: assert property (@(posedge clock) disable iff (!resetn)
		(srcFlags.grp2[0] && en2_r[0] && !globalPrio_r) |=> irqHigh)
		else $error("compare unit request lost");
	a_unimpl_zero: assert property (@(posedge clock) disable iff (!resetn)
		((en2_r & ~`PIE_EN2_MASK) == 8'h00) && ((en3_r & ~`PIE_EN3_MASK) == 8'h00))
		else $error("unimplemented enable bit set");
	a_no_low_off: assert property (@(posedge clock) disable iff (!resetn)
		!globalPrio_r |=> !irqLow)
		else $error("low request without priority mode");
	a_pri_reset: assert property (@(posedge clock)
		$rose(resetn) |-> (pri2_r == `PIE_PRI2_MASK && en2_r == 8'h00))
		else $error("reset values wrong");
endmodule : pie_ctrl

// ---- hdl/pie_params.svh ----
// Purpose: constants for the peripheral interrupt enable and priority block
// Assumes: Avalon-MM word addressing, 8-bit registers in low data bits
// Notes: offsets are word indices
`ifndef PIE_PARAMS_SVH
`define PIE_PARAMS_SVH
`define PIE_OFF_EN2       3'h0
`define PIE_OFF_EN3       3'h1
`define PIE_OFF_PRI1      3'h2
`define PIE_OFF_PRI2      3'h3
`define PIE_OFF_PRI3      3'h4
`define PIE_OFF_CTRL      3'h5
`define PIE_OFF_STATUS    3'h6
`define PIE_OFF_STCLR     3'h7
`define PIE_EN2_MASK      8'hCF
`define PIE_EN3_MASK      8'h40
`define PIE_PRI1_MASK     8'h7F
`define PIE_PRI2_MASK     8'hCF
`define PIE_PRI3_MASK     8'h70
`define PIE_EN_RST        8'h00
`define PIE_PRI_RST       8'hFF
`define PIE_STAT_W        3
`define PIE_DATA_W        8
`endif

// ---- hdl/pie_pkg.sv ----
// Purpose: types for the peripheral interrupt enable and priority block
// Assumes: none
// Notes: none
package pie_pkg;
	typedef struct packed {
		logic [2:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} pie_avreq_s;
	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} pie_avrsp_s;
	typedef struct packed {
		logic [7:0] grp1;
		logic [7:0] grp2;
		logic [7:0] grp3;
	} pie_srcvec_s;
	typedef enum logic [1:0] {
		PIE_IDLE = 2'b01,
		PIE_DONE = 2'b10
	} pie_bus_e;
endpackage : pie_pkg

// ---- hdl/pie_route.sv ----
// Purpose: gates and routes one 8-bit group of interrupt requests
// Assumes: flags, enables and priorities on the block clock
// Notes: purely combinational
`timescale 1ns/10ps
module pie_route #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] flags,     // raw requests
	input  wire logic [WIDTH-1:0] enables,   // enable bits
	input  wire logic [WIDTH-1:0] prios,     // priority bits
	input  wire logic             prioOn,    // global priority enable
	output logic      [WIDTH-1:0] reqHigh,   // routed to high level
	output logic      [WIDTH-1:0] reqLow     // routed to low level
);
	initial begin
		if (WIDTH < 1) $error("pie_route: WIDTH must be positive");
	end
	logic [WIDTH-1:0] gated;
	always_comb begin
		gated = flags & enables;
		// without priority mode everything goes high
		reqHigh = prioOn ? (gated & prios) : gated;
		reqLow  = prioOn ? (gated & ~prios) : '0;
	end
endmodule : pie_route

// ---- bench/pie_core_model.sv ----
// Purpose: core-side model that counts interrupt entries per level
// Assumes: level requests on the block clock
// Notes: an entry is counted on each rising request
`timescale 1ns/10ps
module pie_core_model (
	input  wire logic       clock,   // block clock
	input  wire logic       resetn,  // sync reset, active low
	input  wire logic       irqHigh, // high-priority request
	input  wire logic       irqLow,  // low-priority request
	output logic      [7:0] hiCount, // high entries taken
	output logic      [7:0] loCount  // low entries taken
);
	logic prevHi_r;
	logic prevLo_r;
	always_ff @(posedge clock) begin
		if (!resetn) begin
			prevHi_r <= 1'b0;
			prevLo_r <= 1'b0;
			hiCount  <= 8'h00;
			loCount  <= 8'h00;
		end else begin
			prevHi_r <= irqHigh;
			prevLo_r <= irqLow;
			if (irqHigh && !prevHi_r) hiCount <= hiCount + 8'h01; // high vector
			if (irqLow && !prevLo_r) loCount <= loCount + 8'h01; // low vector
		end
	end
endmodule : pie_core_model

// ---- bench/pie_ctrl_tb.sv ----
// Purpose: self-checking bench for the interrupt enable and priority block
// Assumes: one wait cycle per access, irq one cycle after flag and enable
// Notes: status bit 2 is compared only in the reset read, its meaning is loose
`timescale 1ns/10ps
`include "pie_params.svh"
module pie_ctrl_tb;
	import pie_pkg::*;
	logic        clock;
	logic        resetn;
	pie_avreq_s  avReq;
	pie_avrsp_s  avRsp;
	pie_srcvec_s srcFlags;
	logic        irqHigh;
	logic        irqLow;
	logic        irqOut;
	logic [7:0]  hiCount;
	logic [7:0]  loCount;
	logic [31:0] rd;
	int          err_count;
	int          num_checks;
	localparam logic [7:0] RST [8] = '{`PIE_EN_RST, `PIE_EN_RST, `PIE_PRI1_MASK,
		`PIE_PRI2_MASK, `PIE_PRI3_MASK, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] MSK [8] = '{`PIE_EN2_MASK, `PIE_EN3_MASK, `PIE_PRI1_MASK,
		`PIE_PRI2_MASK, `PIE_PRI3_MASK, 8'h0F, 8'h00, 8'h00};
	localparam int BITS [6] = '{7, 6, 3, 2, 1, 0};
	pie_ctrl pie_ctrl_i (.clock(clock), .resetn(resetn), .avReq(avReq), .avRsp(avRsp),
		.srcFlags(srcFlags), .irqHigh(irqHigh), .irqLow(irqLow), .irqOut(irqOut));
	pie_core_model pie_core_model_i (.clock(clock), .resetn(resetn), .irqHigh(irqHigh),
		.irqLow(irqLow), .hiCount(hiCount), .loCount(loCount));
	always #10 clock = ~clock;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// request held until the rising edge that samples waitrequest low
	task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avReq <= '{address: a, read: !wr, write: wr, writedata: {24'h00_0000, d}};
		do begin
			@(posedge clock);
			n++;
		end while (avRsp.waitrequest !== 1'b0 && n < 50);
		if (n == 50) err_count++;
		rd = avRsp.readdata;
		avReq <= '0;
	endtask : acc
	task automatic settle(input pie_srcvec_s f);
		@(posedge clock);
		srcFlags <= f;
		repeat (2) @(posedge clock);
		#1;
	endtask : settle
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			acc(1'b0, i[2:0], 8'h00);
			chk(rd, {24'h00_0000, RST[i]}); // reset values
		end
		chk({irqHigh, irqLow, irqOut}, 3'b000); // quiet after reset
	endtask : t_reset
	task automatic t_unimpl;
		for (int i = 0; i < 8; i++) acc(1'b1, i[2:0], 8'hFF);
		for (int i = 0; i < 8; i++) begin
			acc(1'b0, i[2:0], 8'h00);
			if (i != 6) chk(rd, {24'h00_0000, MSK[i]}); // unused bits read 0
		end
		for (int i = 0; i < 6; i++) acc(1'b1, i[2:0], 8'h00);
	endtask : t_unimpl
	task automatic t_gate;
		acc(1'b1, `PIE_OFF_EN2, 8'h00);
		settle({8'h00, 8'hCF, 8'h00});
		chk(irqHigh, 1'b0); // flag without enable is held back
		foreach (BITS[k]) begin
			acc(1'b1, `PIE_OFF_EN2, 8'h01 << BITS[k]);
			settle({8'h00, 8'h01 << BITS[k], 8'h00});
			chk({irqHigh, irqLow}, 2'b10); // pass
			settle({8'h00, 8'hCF & ~(8'h01 << BITS[k]), 8'h00});
			chk(irqHigh, 1'b0); // others masked
		end
	endtask : t_gate
	task automatic t_prio;
		acc(1'b1, `PIE_OFF_CTRL, 8'h01);
		acc(1'b1, `PIE_OFF_EN2, 8'h01);
		acc(1'b1, `PIE_OFF_PRI2, 8'h01);
		settle({8'h00, 8'h01, 8'h00});
		chk({irqHigh, irqLow}, 2'b10); // priority one goes high
		acc(1'b1, `PIE_OFF_PRI2, 8'h00);
		settle({8'h00, 8'h01, 8'h00});
		chk({irqHigh, irqLow}, 2'b01); // priority zero goes low
		settle({8'h01, 8'h00, 8'h00});
		chk({irqHigh, irqLow}, 2'b01); // group one own bit
		acc(1'b1, `PIE_OFF_EN3, 8'h40);
		settle({8'h00, 8'h00, 8'h40});
		chk({irqHigh, irqLow}, 2'b01); // group three own bit
		acc(1'b1, `PIE_OFF_CTRL, 8'h00);
		settle({8'h00, 8'h00, 8'h40});
		chk({irqHigh, irqLow}, 2'b10); // priorities ignored when off
	endtask : t_prio
	task automatic t_status;
		settle('0);
		acc(1'b1, `PIE_OFF_STCLR, 8'hFF);
		acc(1'b1, `PIE_OFF_EN2, 8'h01);
		settle({8'h00, 8'h01, 8'h00});
		acc(1'b0, `PIE_OFF_STATUS, 8'h00);
		chk(rd & 32'h0000_0003, 32'h0000_0001);
		chk(irqOut, 1'b0);
		acc(1'b1, `PIE_OFF_CTRL, 8'h02);
		#1;
		chk(irqOut, 1'b1);
		acc(1'b1, `PIE_OFF_STCLR, 8'h01);
		#1;
		chk(irqOut, 1'b0);
	endtask : t_status
	task automatic summarize;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	initial begin
		#200000;
		err_count++;
		summarize();
	end
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		avReq = '0;
		srcFlags = '0;
		err_count = 0;
		num_checks = 0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		t_reset();
		t_unimpl();
		t_gate();
		t_prio();
		t_status();
		chk(loCount != 8'h00, 1'b1); // core saw low entries
		summarize();
	end
endmodule : pie_ctrl_tb
